/* File: cmp_event_defs.svh */
// cmp_event_defs.svh: offsets, field positions, reset values and modes
// for the comparator event control block; included by name only.
`ifndef CMP_EVENT_DEFS_SVH
`define CMP_EVENT_DEFS_SVH

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define CMP_ADDR_W          4
`define CMP_OFS_STATUS_CTRL 4'h0
`define CMP_OFS_SYS_OPTS    4'h1

// ----------------------------------------------------------------------
// status, control and option fields
// ----------------------------------------------------------------------
`define CMP_BIT_ENABLE      7
`define CMP_BIT_REF_SEL     6
`define CMP_BIT_FLAG        5
`define CMP_BIT_IRQ_EN      4
`define CMP_BIT_RESULT      3
`define CMP_BIT_PIN_EN      2
`define CMP_MODE_HI         1
`define CMP_MODE_LO         0
`define CMP_BIT_CAPTURE     0

`define CMP_RESET_CTRL      8'h00
`define CMP_RESET_OPTS      8'h00

// ----------------------------------------------------------------------
// event mode codes
// ----------------------------------------------------------------------
`define CMP_MODE_FALL0      2'h0
`define CMP_MODE_RISE       2'h1
`define CMP_MODE_FALL2      2'h2
`define CMP_MODE_BOTH       2'h3

`endif

/* File: cmp_event_pkg.sv */
// cmp_event_pkg.sv: types shared by the comparator event control files.
// assumes nothing beyond a SystemVerilog compiler.
package cmp_event_pkg;

	typedef logic [7:0] reg_byte_t;
	typedef logic [1:0] event_mode_t;

endpackage

/* File: cmp_sync_if.sv */
// cmp_sync_if.sv: carries the synchronised comparator result and its
// edges between the top and the edge detector.
// assumes one clock domain on both sides.
`timescale 1ns/1ps

interface cmp_sync_if;
	logic level;
	logic rise;
	logic fall;

	modport source
	(
		output level,
		output rise,
		output fall
	);
	modport sink
	(
		input level,
		input rise,
		input fall
	);
endinterface

/* File: cmp_edge_sync.sv */
// cmp_edge_sync.sv: two-stage synchroniser and edge finder for the
// asynchronous comparator result.
// assumes i_raw is asynchronous to i_sys_clk.
`timescale 1ns/1ps

module cmp_edge_sync
(
	// clock and reset
	input  wire logic       i_sys_clk,
	input  wire logic       i_resetn,
	// raw comparator result and enable
	input  wire logic       i_raw,
	input  wire logic       i_enable,
	// synchronised result
	cmp_sync_if.source      sync
);
	logic meta_q;
	logic meta_d;
	logic stab_q;
	logic stab_d;
	logic last_q;
	logic last_d;
	logic en_q;
	logic en_d;

	// first stage feeds only the second stage
	always_comb
	begin
		meta_d = i_raw;
		stab_d = meta_q;
		last_d = i_enable ? stab_q : 1'b0;
		en_d   = i_enable;
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			meta_q <= 1'b0;
			stab_q <= 1'b0;
			last_q <= 1'b0;
			en_q   <= 1'b0;
		end
		else
		begin
			meta_q <= meta_d;
			stab_q <= stab_d;
			last_q <= last_d;
			en_q   <= en_d;
		end
	end

	// edges only count while enabled, so enabling never fakes an edge
	// from the stale reset value of last_q
	assign sync.level = i_enable & stab_q;
	assign sync.rise  = i_enable & en_q & stab_q & ~last_q;
	assign sync.fall  = i_enable & en_q & ~stab_q & last_q;

	a_rise_after_low : assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		sync.rise |-> $past(stab_q) == 1'b0 && stab_q)
		else $error("rise without low-to-high step");
endmodule

/* File: cmp_event_ctrl.sv */
// cmp_event_ctrl.sv: comparator event control top: register, edge
// events, sticky flag, interrupt, output pin and capture routing.
// assumes a simple strobe bus master on i_sys_clk and an analog core
// whose result is asynchronous.
`timescale 1ns/1ps
`include "cmp_event_defs.svh"

// Operation
// - bit 7 enables comparing and event detection; clear disables block
// - bit 6 picks non-inverting input: 0 external pin, 1 bandgap
// - bit 5 flag sets on selected event; cleared only by writing one
// - interrupt requested while flag set and bit 4 enable is one
// - bit 3 reads present result; zero at reset and when disabled
// - bit 2 drives result onto output pin; otherwise pin shows nothing
// - bits 1:0 mode: 00 and 10 falling, 01 rising, 11 either edge
// - enabled block keeps running in wait; flagged event wakes processor
// - in light stop block keeps comparing, driving pin, flagging, waking
// - stop exit by reset returns every bit to reset state
// - deep stop powers down; wake finds reset values
// - in debug halt block compares and flags as in run mode
// - capture route option feeds result to timer channel 0, pin lost
// - result is one when non-inverting input exceeds inverting input
module cmp_event_ctrl
	import cmp_event_pkg::*;
(
	// clock and reset
	input  wire logic                        i_sys_clk,
	input  wire logic                        i_resetn,
	// register bus
	input  wire logic [`CMP_ADDR_W-1:0]      i_addr,
	input  wire cmp_event_pkg::reg_byte_t    i_wdata,
	input  wire logic                        i_wr,
	input  wire logic                        i_rd,
	output cmp_event_pkg::reg_byte_t         o_rdata,
	// analog core
	input  wire logic                        i_cmp_result,
	output logic                             o_cmp_enable,
	output logic                             o_reference_select,
	// pins and system
	output logic                             o_compare_output_pin,
	output logic                             o_compare_output_oe_n,
	output logic                             o_capture_input,
	output logic                             o_timer_pin_blocked,
	output logic                             o_irq
);
	import cmp_event_pkg::*;

	// ------------------------------------------------------------------
	// control state
	// ------------------------------------------------------------------
	reg_byte_t   ctrl_q;
	reg_byte_t   ctrl_d;
	logic        flag_q;
	logic        flag_d;
	logic        route_q;
	logic        route_d;
	reg_byte_t   rdata_q;
	reg_byte_t   rdata_d;
	logic        irq_q;
	logic        irq_d;
	logic        pin_q;
	logic        pin_d;
	logic        pin_oe_n_q;
	logic        pin_oe_n_d;
	logic        cap_q;
	logic        cap_d;
	logic        blk_q;
	logic        blk_d;
	logic        en_out_q;
	logic        en_out_d;
	logic        ref_q;
	logic        ref_d;

	cmp_sync_if  sync ();

	logic        enable;
	event_mode_t mode;
	logic        hit;

	assign enable = ctrl_q[`CMP_BIT_ENABLE];
	assign mode   = ctrl_q[`CMP_MODE_HI:`CMP_MODE_LO];

	// ------------------------------------------------------------------
	// synchroniser and edges
	// ------------------------------------------------------------------
	cmp_edge_sync u_sync
	(
		.i_sys_clk (i_sys_clk),
		.i_resetn  (i_resetn),
		.i_raw     (i_cmp_result),
		.i_enable  (enable),
		.sync      (sync.source)
	);

	function automatic logic event_hit(event_mode_t m, logic r, logic f);
		unique case (m)
			`CMP_MODE_RISE : event_hit = r;
			`CMP_MODE_BOTH : event_hit = r | f;
			default        : event_hit = f;
		endcase
	endfunction

	// wait, light stop and debug halt leave the bus clock running, so
	// the block simply keeps working; deep stop and reset exits reach
	// it only through i_resetn
	assign hit = enable & event_hit(mode, sync.rise, sync.fall);

	// ------------------------------------------------------------------
	// register next state
	// ------------------------------------------------------------------
	logic wr_ctrl;
	logic wr_opts;
	assign wr_ctrl = i_wr && (i_addr == `CMP_OFS_STATUS_CTRL);
	assign wr_opts = i_wr && (i_addr == `CMP_OFS_SYS_OPTS);

	always_comb
	begin
		ctrl_d  = ctrl_q;
		flag_d  = flag_q;
		route_d = route_q;
		if (wr_ctrl)
		begin
			ctrl_d[`CMP_BIT_ENABLE]  = i_wdata[`CMP_BIT_ENABLE];
			ctrl_d[`CMP_BIT_REF_SEL] = i_wdata[`CMP_BIT_REF_SEL];
			ctrl_d[`CMP_BIT_IRQ_EN]  = i_wdata[`CMP_BIT_IRQ_EN];
			ctrl_d[`CMP_BIT_PIN_EN]  = i_wdata[`CMP_BIT_PIN_EN];
			ctrl_d[`CMP_MODE_HI:`CMP_MODE_LO] =
				i_wdata[`CMP_MODE_HI:`CMP_MODE_LO];
			if (i_wdata[`CMP_BIT_FLAG])
				flag_d = 1'b0;
		end
		if (wr_opts)
			route_d = i_wdata[`CMP_BIT_CAPTURE];
		// set wins over a clear in the same cycle
		if (hit)
			flag_d = 1'b1;
		// flag and result bits are not held in ctrl
		ctrl_d[`CMP_BIT_FLAG]   = 1'b0;
		ctrl_d[`CMP_BIT_RESULT] = 1'b0;
	end

	// ------------------------------------------------------------------
	// outputs next state
	// ------------------------------------------------------------------
	always_comb
	begin
		rdata_d = 8'h00;
		if (i_rd)
		begin
			unique case (i_addr)
				`CMP_OFS_STATUS_CTRL :
				begin
					rdata_d = ctrl_q;
					rdata_d[`CMP_BIT_FLAG]   = flag_q;
					rdata_d[`CMP_BIT_RESULT] = sync.level;
				end
				`CMP_OFS_SYS_OPTS :
					rdata_d[`CMP_BIT_CAPTURE] = route_q;
				default :
					rdata_d = 8'h00;
			endcase
		end
		irq_d      = flag_d & ctrl_d[`CMP_BIT_IRQ_EN];
		pin_d      = enable & ctrl_q[`CMP_BIT_PIN_EN] & sync.level;
		pin_oe_n_d = ~(enable & ctrl_q[`CMP_BIT_PIN_EN]);
		cap_d      = route_q & sync.level;
		blk_d      = route_q;
		en_out_d   = ctrl_d[`CMP_BIT_ENABLE];
		// bandgap buffer must already be on; that is software's job
		ref_d      = ctrl_d[`CMP_BIT_REF_SEL];
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			ctrl_q     <= `CMP_RESET_CTRL;
			flag_q     <= 1'b0;
			route_q    <= 1'b0;
			rdata_q    <= 8'h00;
			irq_q      <= 1'b0;
			pin_q      <= 1'b0;
			pin_oe_n_q <= 1'b1;
			cap_q      <= 1'b0;
			blk_q      <= 1'b0;
			en_out_q   <= 1'b0;
			ref_q      <= 1'b0;
		end
		else
		begin
			ctrl_q     <= ctrl_d;
			flag_q     <= flag_d;
			route_q    <= route_d;
			rdata_q    <= rdata_d;
			irq_q      <= irq_d;
			pin_q      <= pin_d;
			pin_oe_n_q <= pin_oe_n_d;
			cap_q      <= cap_d;
			blk_q      <= blk_d;
			en_out_q   <= en_out_d;
			ref_q      <= ref_d;
		end
	end

	assign o_rdata               = rdata_q;
	assign o_irq                 = irq_q;
	assign o_compare_output_pin  = pin_q;
	assign o_compare_output_oe_n = pin_oe_n_q;
	assign o_capture_input       = cap_q;
	assign o_timer_pin_blocked   = blk_q;
	assign o_cmp_enable          = en_out_q;
	assign o_reference_select    = ref_q;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	a_enable_follows_write : assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		wr_ctrl |=> o_cmp_enable == $past(i_wdata[`CMP_BIT_ENABLE]))
		else $error("enable output did not follow write");

	a_ref_follows_write : assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		wr_ctrl |=> o_reference_select == $past(i_wdata[`CMP_BIT_REF_SEL]))
		else $error("reference select did not follow write");

	a_flag_set_event : assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		hit |=> flag_q)
		else $error("event lost");

	a_flag_sticky : assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		flag_q && !(wr_ctrl && i_wdata[`CMP_BIT_FLAG]) |=> flag_q)
		else $error("flag cleared without write of one");

	a_irq_gate : assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		o_irq == (flag_q && ctrl_q[`CMP_BIT_IRQ_EN]))
		else $error("interrupt does not match flag and enable");

	a_result_disabled : assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		i_rd && i_addr == `CMP_OFS_STATUS_CTRL && !enable
		|=> o_rdata[`CMP_BIT_RESULT] == 1'b0)
		else $error("result read nonzero while disabled");

	a_pin_off : assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		!ctrl_q[`CMP_BIT_PIN_EN] |=> o_compare_output_oe_n
		&& !o_compare_output_pin)
		else $error("pin driven while disabled");

	a_rise_mode : assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		enable && mode == `CMP_MODE_RISE && sync.fall && !sync.rise
		|-> !hit)
		else $error("falling edge hit in rising mode");

	a_capture_route : assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		!route_q |=> !o_capture_input)
		else $error("capture driven with routing off");

	// a clear that meets a new event is left to a_flag_set_event
	a_flag_clear_write : assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		wr_ctrl && i_wdata[`CMP_BIT_FLAG] && !hit |=> !flag_q)
		else $error("flag not cleared by write of one");

	a_flag_readback : assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		i_rd && i_addr == `CMP_OFS_STATUS_CTRL
		|=> o_rdata[`CMP_BIT_FLAG] == $past(flag_q))
		else $error("flag bit read back wrong");

	a_no_event_off : assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		!enable && !flag_q |=> !flag_q)
		else $error("flag set while block disabled");

	a_pin_follows : assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		enable && ctrl_q[`CMP_BIT_PIN_EN] |=> !o_compare_output_oe_n
		&& (o_compare_output_pin == $past(sync.level)))
		else $error("pin does not follow result");

	a_mode_falls : assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		enable && mode != `CMP_MODE_RISE && sync.fall |-> hit)
		else $error("falling edge missed in falling mode");

	a_route_blocks : assert property (
		@(posedge i_sys_clk) disable iff (!i_resetn)
		1'b1 |=> o_timer_pin_blocked == $past(route_q))
		else $error("timer pin block does not follow routing");
endmodule

/* File: cmp_core_model.sv */
// cmp_core_model.sv: behavioural analog comparator core, far side of
// the block; levels in millivolts, changed by the bench on a clock edge.
`timescale 1ns/1ps

module cmp_core_model
#(
	parameter int BG_MV = 1200
)
(
	// control from the block, bandgap buffer enable from the bench
	input  wire logic        i_enable,
	input  wire logic        i_ref_sel,
	input  wire logic        i_bg_buf_en,
	// analog levels
	input  wire logic [11:0] i_pos_mv,
	input  wire logic [11:0] i_neg_mv,
	// result
	output logic             o_result = 1'b0
);
	logic [11:0] ref_mv;

	// an unpowered or unreferenced core floats: flip on every change
	always @(i_enable, i_ref_sel, i_bg_buf_en, i_pos_mv, i_neg_mv)
	begin
		ref_mv = i_ref_sel ? 12'(BG_MV) : i_pos_mv;
		if (i_enable && (!i_ref_sel || i_bg_buf_en))
			o_result = ref_mv > i_neg_mv;
		else
			o_result = !o_result;
	end
endmodule

/* File: test_comparator_event_control.sv */
// test_comparator_event_control.sv: self-checking bench for the block.
// assumes the core model above and the design files on the path.
`timescale 1ns/1ps
`include "cmp_event_defs.svh"

module test_comparator_event_control;
	import cmp_event_pkg::*;

	logic        i_sys_clk = 1'b0;
	logic        i_resetn  = 1'b0;
	logic [3:0]  i_addr    = 4'h0;
	reg_byte_t   i_wdata   = 8'h00;
	logic        i_wr      = 1'b0;
	logic        i_rd      = 1'b0;
	reg_byte_t   o_rdata;
	logic        cmp_res;
	logic        cmp_en;
	logic        ref_sel;
	logic        pin;
	logic        pin_oe_n;
	logic        cap;
	logic        blocked;
	logic        o_irq;
	logic [11:0] pos_mv    = 12'h000;
	logic [11:0] neg_mv    = 12'h000;
	logic        bg_en     = 1'b0;
	int          error_cnt = 0;
	int          checked   = 0;

	always #20 i_sys_clk = ~i_sys_clk;

	cmp_event_ctrl uut
	(
		.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_cmp_result(cmp_res), .o_cmp_enable(cmp_en),
		.o_reference_select(ref_sel), .o_compare_output_pin(pin),
		.o_compare_output_oe_n(pin_oe_n), .o_capture_input(cap),
		.o_timer_pin_blocked(blocked), .o_irq(o_irq)
	);

	cmp_core_model core
	(
		.i_enable(cmp_en), .i_ref_sel(ref_sel), .i_bg_buf_en(bg_en),
		.i_pos_mv(pos_mv), .i_neg_mv(neg_mv), .o_result(cmp_res)
	);

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic logic hit(input event_mode_t md, input logic up);
		if (up)
			return md == `CMP_MODE_RISE || md == `CMP_MODE_BOTH;
		return md != `CMP_MODE_RISE;
	endfunction

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string nm, input reg_byte_t e, reg_byte_t g);
		checked++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [3:0] a, input reg_byte_t d);
		@(posedge i_sys_clk);
		i_addr  <= a;
		i_wdata <= d;
		i_wr    <= 1'b1;
		@(posedge i_sys_clk);
		i_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output reg_byte_t d);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_sys_clk);
		i_rd   <= 1'b0;
		#1 d = o_rdata;
	endtask

	task automatic rchk(input logic [3:0] a, input reg_byte_t e);
		reg_byte_t d;
		rd(a, d);
		chk("register", e, d);
	endtask

	// new levels, then let sync, edge and flag settle
	task automatic lvl(input logic [11:0] p, input logic [11:0] n);
		@(posedge i_sys_clk);
		pos_mv <= p;
		neg_mv <= n;
		repeat (6) @(posedge i_sys_clk);
	endtask

	initial
	begin
		#800000;
		error_cnt++;
		report_and_stop();
	end

	// ------------------------------------------------------------------
	// tests
	// ------------------------------------------------------------------
	initial
	begin
		reg_byte_t   d;
		event_mode_t md;
		logic [15:0] s;
		s = 16'hfa5a;
		repeat (10) @(posedge i_sys_clk);
		i_resetn <= 1'b1;
		rchk(4'h0, `CMP_RESET_CTRL);
		rchk(4'h1, `CMP_RESET_OPTS);
		chk("oe_n", 8'h01, {7'h0, pin_oe_n});
		$display("test reset done");
		lvl(12'd900, 12'd500);
		wr(4'h0, 8'h80);
		repeat (4) @(posedge i_sys_clk);
		rchk(4'h0, 8'h88);
		wr(4'h0, 8'h00);
		rchk(4'h0, 8'h00);
		$display("test result done");
		for (int m = 0; m < 4; m++)
		begin
			md = event_mode_t'(m);
			wr(4'h0, {6'h28, md});
			lvl(12'd100, 12'd500);
			// enabling may settle the core through an edge: clear it
			wr(4'h0, {6'h28, md});
			lvl(12'd900, 12'd500);
			rchk(4'h0, {2'h2, hit(md, 1'b1), 3'h2, md});
			wr(4'h0, {6'h28, md});
			lvl(12'd100, 12'd500);
			rchk(4'h0, {2'h2, hit(md, 1'b0), 3'h0, md});
		end
		wr(4'h0, 8'h83);
		rchk(4'h0, 8'ha3);
		wr(4'h0, 8'h93);
		repeat (2) @(posedge i_sys_clk);
		chk("irq", 8'h01, {7'h0, o_irq});
		wr(4'h0, 8'hb3);
		rchk(4'h0, 8'h93);
		chk("irq", 8'h00, {7'h0, o_irq});
		wr(4'h0, 8'h83);
		lvl(12'd900, 12'd500);
		rchk(4'h0, 8'hab);
		chk("irq", 8'h00, {7'h0, o_irq});
		$display("test modes done");
		wr(4'h0, 8'ha4);
		repeat (3) @(posedge i_sys_clk);
		chk("pin", 8'h01, {7'h0, pin});
		chk("oe_n", 8'h00, {7'h0, pin_oe_n});
		lvl(12'd100, 12'd500);
		chk("pin", 8'h00, {7'h0, pin});
		wr(4'h0, 8'ha0);
		lvl(12'd900, 12'd500);
		chk("oe_n", 8'h01, {7'h0, pin_oe_n});
		chk("pin", 8'h00, {7'h0, pin});
		$display("test pin done");
		bg_en <= 1'b1;
		lvl(12'd900, 12'd1000);
		wr(4'h0, 8'he0);
		repeat (4) @(posedge i_sys_clk);
		rchk(4'h0, 8'hc8);
		chk("ref_sel", 8'h01, {7'h0, ref_sel});
		chk("cmp_en", 8'h01, {7'h0, cmp_en});
		wr(4'h1, 8'h01);
		repeat (3) @(posedge i_sys_clk);
		chk("capture", 8'h01, {7'h0, cap});
		chk("blocked", 8'h01, {7'h0, blocked});
		rchk(4'h1, 8'h01);
		wr(4'h7, 8'hff);
		rchk(4'h7, 8'h00);
		rchk(4'h1, 8'h01);
		$display("test reference done");
		wr(4'h0, 8'h23);
		lvl(12'd900, 12'd500);
		lvl(12'd100, 12'd500);
		rchk(4'h0, 8'h03);
		chk("capture", 8'h00, {7'h0, cap});
		wr(4'h0, 8'hd7);
		@(posedge i_sys_clk);
		i_resetn <= 1'b0;
		repeat (2) @(posedge i_sys_clk);
		i_resetn <= 1'b1;
		rchk(4'h0, `CMP_RESET_CTRL);
		rchk(4'h1, `CMP_RESET_OPTS);
		chk("irq", 8'h00, {7'h0, o_irq});
		chk("cmp_en", 8'h00, {7'h0, cmp_en});
		$display("test reset again done");
		wr(4'h0, 8'h80);
		repeat (16)
		begin
			s = lfsr(s);
			lvl(s[11:0], {s[3:0], s[11:4]});
			rd(4'h0, d);
			chk("result", {7'h0, s[11:0] > {s[3:0], s[11:4]}},
				{7'h0, d[3]});
		end
		$display("test random done");
		report_and_stop();
	end
endmodule
